// [common/lswp_defines.svh]
`ifndef LSWP_DEFINES_SVH
`define LSWP_DEFINES_SVH

// Geometry of the status map.
`define LSWP_WORD_W          16
`define LSWP_NUM_STATIONS    64
`define LSWP_CIRCUITS_PER_ST 24
`define LSWP_NUM_CIRCUITS    1536
`define LSWP_ST_IDX_W        6
`define LSWP_CI_SLOT_W       5
`define LSWP_CI_IDX_W        11

// Input register numbers as seen by the remote client.
`define LSWP_ST_BASE_ADDR    16'h0004
`define LSWP_ST_LAST_ADDR    16'h0100
`define LSWP_CI_BASE_ADDR    16'h0104
`define LSWP_CI_LAST_ADDR    16'h0703

// Substation word field positions.
`define LSWP_ST_UNUSED_HI    15
`define LSWP_ST_UNUSED_LO    13
`define LSWP_ST_TEST_FAULT   12
`define LSWP_ST_LOOP_OPEN    11
`define LSWP_ST_CHARGER      10
`define LSWP_ST_CIRCUITS     9
`define LSWP_ST_SERVICE      8
`define LSWP_ST_DEEP_DIS     7
`define LSWP_ST_CHARGING     6
`define LSWP_ST_ERROR        5
`define LSWP_ST_BATTERY      4
`define LSWP_ST_TESTING      3
`define LSWP_ST_MAINS        2
`define LSWP_ST_LINK         1
`define LSWP_ST_PRESENT      0

// Circuit word field positions.
`define LSWP_CI_TRIG_HI      15
`define LSWP_CI_TRIG_LO      14
`define LSWP_CI_FIT_FAULT    13
`define LSWP_CI_FIT_HI       12
`define LSWP_CI_FIT_LO       8
`define LSWP_CI_CUR_FAIL     7
`define LSWP_CI_TEST_HI      6
`define LSWP_CI_TEST_LO      5
`define LSWP_CI_CARD_FAULT   4
`define LSWP_CI_MODE_HI      3
`define LSWP_CI_MODE_LO      2
`define LSWP_CI_LINK         1
`define LSWP_CI_PRESENT      0

// Reset value of every status word: nothing installed.
`define LSWP_WORD_RESET      16'h0000

`endif

// [common/lswp_pkg.sv]
`include "lswp_defines.svh"

package lswp_pkg;

    // External-trigger configuration of a circuit.
    typedef enum logic [1:0] {
        LSWP_TRIG_UNCONF   = 2'h0,
        LSWP_TRIG_DEFAULT  = 2'h1,
        LSWP_TRIG_OFF      = 2'h2,
        LSWP_TRIG_MODIFIED = 2'h3
    } lswp_trig_e;

    // Test status of a circuit; code 3 is reserved.
    typedef enum logic [1:0] {
        LSWP_TEST_OK       = 2'h0,
        LSWP_TEST_RUNNING  = 2'h1,
        LSWP_TEST_ERROR    = 2'h2,
        LSWP_TEST_RESERVED = 2'h3
    } lswp_test_e;

    // Default operating mode of a circuit.
    typedef enum logic [1:0] {
        LSWP_MODE_UNCONF   = 2'h0,
        LSWP_MODE_DISABLED = 2'h1,
        LSWP_MODE_MAINT    = 2'h2,
        LSWP_MODE_NONMAINT = 2'h3
    } lswp_mode_e;

    typedef logic [`LSWP_WORD_W-1:0] lswp_word_t;

    // Whole state of the register bank.
    typedef struct packed {
        lswp_word_t [`LSWP_NUM_STATIONS-1:0] station;
        lswp_word_t [`LSWP_NUM_CIRCUITS-1:0] circuit;
        logic                                rd_valid;
        lswp_word_t                          rd_data;
        logic                                rd_illegal;
        logic                                wr_refused;
        logic                                st_changed;
        logic                                ci_changed;
    } lswp_state_s;

endpackage

// [test/lswp_client.sv]
`timescale 1ns/1ps

module lswp_client (
    // Clock.
    input  wire logic        i_clk,
    // Requests towards the bank.
    output logic             o_rd_req,
    output logic [15:0]      o_rd_addr,
    output logic             o_wr_req,
    output logic [15:0]      o_wr_addr,
    output logic [15:0]      o_wr_data,
    // Answers from the bank.
    input  wire logic        i_rd_valid,
    input  wire logic [15:0] i_rd_data,
    input  wire logic        i_rd_illegal,
    input  wire logic        i_wr_refused
);
    // Idle at time zero.
    initial begin
        o_rd_req  = 1'b0;
        o_rd_addr = 16'hffff;
        o_wr_req  = 1'b0;
        o_wr_addr = 16'hffff;
        o_wr_data = 16'hffff;
    end

    // One input register per request, as the read-input-registers function fetches it.
    // Released lines show the inverse so that stale addresses cannot pass for held ones.
    task automatic read_input(input logic [15:0] a, input int gap, output logic [15:0] d,
                              output logic ill, output logic v);
        repeat (gap) @(posedge i_clk);
        @(posedge i_clk);
        o_rd_req  <= 1'b1;
        o_rd_addr <= a;
        @(posedge i_clk);
        o_rd_req  <= 1'b0;
        o_rd_addr <= ~a;
        #1;
        v   = i_rd_valid;
        d   = i_rd_data;
        ill = i_rd_illegal;
    endtask

    // A client write attempt; the bank must refuse it.
    task automatic write_reg(input logic [15:0] a, input logic [15:0] d, output logic refused);
        @(posedge i_clk);
        o_wr_req  <= 1'b1;
        o_wr_addr <= a;
        o_wr_data <= d;
        @(posedge i_clk);
        o_wr_req  <= 1'b0;
        o_wr_addr <= ~a;
        o_wr_data <= ~d;
        #1;
        refused = i_wr_refused;
    endtask
endmodule // lswp_client

// [test/lswp_status_bank_assertions.sv]
`timescale 1ns/1ps

module lswp_status_bank_chk (
    // Clock and reset.
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    // Requests into the bank.
    input  wire logic        i_st_upd,
    input  wire logic        i_ci_upd,
    input  wire logic        i_rd_req,
    input  wire logic [15:0] i_rd_addr,
    input  wire logic        i_wr_req,
    // Answers from the bank.
    input  wire logic        o_rd_valid,
    input  wire logic [15:0] o_rd_data,
    input  wire logic        o_rd_illegal,
    input  wire logic        o_wr_refused,
    input  wire logic        o_st_changed,
    input  wire logic        o_ci_changed
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    // Decode of the two mapped windows; the voltage words between substations stay unmapped.
    logic st_hit;
    logic ci_hit;
    assign st_hit = (i_rd_addr >= 16'h0004) && (i_rd_addr <= 16'h0100) && (i_rd_addr[1:0] == 2'h0);
    assign ci_hit = (i_rd_addr >= 16'h0104) && (i_rd_addr <= 16'h0703);

    ////////////////////////////////////////////////////////////////////////////////
    AST_RD_ANSWER: assert property (i_rd_req |=> o_rd_valid)
        else $error("read request got no answer");
    AST_RD_QUIET: assert property (!i_rd_req |=> !o_rd_valid && !o_rd_illegal)
        else $error("read answer without a request");
    AST_ST_TOP_ZERO: assert property (i_rd_req && st_hit |=>
        !o_rd_illegal && o_rd_data[15:13] == 3'h0)
        else $error("substation word top bits not zero");
    AST_CI_MAPPED: assert property (i_rd_req && ci_hit |=> !o_rd_illegal)
        else $error("circuit register refused");
    AST_UNMAPPED: assert property (i_rd_req && !st_hit && !ci_hit |=>
        o_rd_illegal && o_rd_data == 16'h0000)
        else $error("unmapped register not refused");
    AST_WR_REFUSED: assert property (i_wr_req |=> o_wr_refused)
        else $error("write not refused");
    AST_WR_NO_EFFECT: assert property (i_wr_req && !i_st_upd && !i_ci_upd |=>
        !o_st_changed && !o_ci_changed)
        else $error("write changed a stored word");
    AST_DATA_HOLD: assert property (!o_rd_valid && !$past(i_rst) |->
        $stable(o_rd_data))
        else $error("read data moved without a read");
    AST_RD_NO_CHANGE: assert property (i_rd_req && !i_st_upd |=> !o_st_changed)
        else $error("read caused a change event");

    // Main scenarios seen at least once.
    COV_ILLEGAL: cover property (i_rd_req ##1 o_rd_illegal);
    COV_ST_CHG: cover property (i_st_upd ##1 o_st_changed);
    COV_CI_CHG: cover property (i_ci_upd ##1 o_ci_changed);
    COV_WR: cover property (i_wr_req ##1 o_wr_refused);
endmodule // lswp_status_bank_chk

bind lswp_status_bank lswp_status_bank_chk u_chk (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_st_upd(i_st_upd), .i_ci_upd(i_ci_upd),
    .i_rd_req(i_rd_req), .i_rd_addr(i_rd_addr), .i_wr_req(i_wr_req), .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data), .o_rd_illegal(o_rd_illegal), .o_wr_refused(o_wr_refused),
    .o_st_changed(o_st_changed), .o_ci_changed(o_ci_changed));

// [test/tb.sv]
`timescale 1ns/1ps

module tb;
    logic        i_ref_clk = 1'b0;
    logic        i_rst     = 1'b1;
    logic        st_upd, ci_upd, rd_req, wr_req, rd_valid, rd_illegal, wr_refused;
    logic        st_chg, ci_chg, refused;
    logic [5:0]  st_idx, ci_st;
    logic [4:0]  ci_slot;
    logic [12:0] st_f;
    logic [15:0] ci_w, rd_addr, wr_addr, wr_data, rd_data, w;
    int          fails = 0;
    int          checks = 0;

    // A 250 MHz reference clock.
    always #2 i_ref_clk = ~i_ref_clk;

    lswp_status_bank u_dut (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_st_upd(st_upd), .i_st_index(st_idx),
        .i_st_test_fault(st_f[12]), .i_st_loop_open(st_f[11]), .i_st_charger_fault(st_f[10]),
        .i_st_circuits_fault(st_f[9]), .i_st_service_active(st_f[8]),
        .i_st_deep_discharge_seen(st_f[7]), .i_st_charging_active(st_f[6]),
        .i_st_general_fault(st_f[5]), .i_st_on_battery(st_f[4]), .i_st_test_running(st_f[3]),
        .i_st_mains_present(st_f[2]), .i_st_link_ok(st_f[1]), .i_st_present(st_f[0]),
        .i_ci_upd(ci_upd), .i_ci_station(ci_st), .i_ci_slot(ci_slot),
        .i_ci_trigger_cfg(lswp_pkg::lswp_trig_e'(ci_w[15:14])), .i_ci_fitting_fault(ci_w[13]),
        .i_ci_fitting_count(ci_w[12:8]), .i_ci_current_check_fail(ci_w[7]),
        .i_ci_test_status(lswp_pkg::lswp_test_e'(ci_w[6:5])), .i_ci_card_fault(ci_w[4]),
        .i_ci_default_mode(lswp_pkg::lswp_mode_e'(ci_w[3:2])), .i_ci_link_ok(ci_w[1]),
        .i_ci_present(ci_w[0]), .i_rd_req(rd_req), .i_rd_addr(rd_addr), .i_wr_req(wr_req),
        .i_wr_addr(wr_addr), .i_wr_data(wr_data), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
        .o_rd_illegal(rd_illegal), .o_wr_refused(wr_refused), .o_st_changed(st_chg),
        .o_ci_changed(ci_chg));

    lswp_client u_cli (
        .i_clk(i_ref_clk), .o_rd_req(rd_req), .o_rd_addr(rd_addr), .o_wr_req(wr_req),
        .o_wr_addr(wr_addr), .o_wr_data(wr_data), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
        .i_rd_illegal(rd_illegal), .i_wr_refused(wr_refused));

    ////////////////////////////////////////////////////////////////////////////////
    // Comparison helpers; case inequality keeps unknowns from passing.
    task automatic chk_word(input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic chk_bit(input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // One read through the client and a check of valid, refusal and data.
    task automatic rd(input logic [15:0] a, input logic [15:0] exp, input logic ill,
                      input int gap);
        logic [15:0] d;
        logic        i;
        logic        v;
        u_cli.read_input(a, gap, d, i, v);
        chk_bit(1'b1, v);
        chk_bit(ill, i);
        chk_word(exp, d);
    endtask

    // Supervisor updates; the change event is registered on the taking edge and checked 1 ns after it.
    task automatic st_put(input logic [5:0] idx, input logic [12:0] f, input logic charging_active);
        @(posedge i_ref_clk);
        st_upd <= 1'b1;
        st_idx <= idx;
        st_f   <= f;
        @(posedge i_ref_clk);
        st_upd <= 1'b0;
        #1 chk_bit(charging_active, st_chg);
    endtask

    task automatic ci_put(input logic [5:0] s, input logic [4:0] c, input logic [15:0] v,
                          input logic charging_active);
        @(posedge i_ref_clk);
        ci_upd  <= 1'b1;
        ci_st   <= s;
        ci_slot <= c;
        ci_w    <= v;
        @(posedge i_ref_clk);
        ci_upd  <= 1'b0;
        #1 chk_bit(charging_active, ci_chg);
    endtask

    task automatic final_report;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Unmapped register numbers around both windows.
    logic [15:0] w_un [6] = '{16'h0000, 16'h0003, 16'h0005, 16'h0101, 16'h0704, 16'hffff};

    // Main sequence.
    initial begin
        st_upd  = 1'b0;
        ci_upd  = 1'b0;
        st_idx  = 6'h00;
        ci_st   = 6'h00;
        ci_slot = 5'h00;
        st_f    = 13'h0000;
        ci_w    = 16'h0000;
        repeat (10) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        rd(16'h0004, 16'h0000, 1'b0, 0);
        rd(16'h0104, 16'h0000, 1'b0, 0);
        // Each substation flag alone lands on its own bit.
        for (int b = 0; b < 13; b++) begin
            st_put(6'h00, 13'h0001 << b, 1'b1);
            rd(16'h0004, 16'h0001 << b, 1'b0, 0);
        end
        st_put(6'h3f, 13'h1fff, 1'b1);
        rd(16'h0100, 16'h1fff, 1'b0, 0);
        st_put(6'h3f, 13'h1fff, 1'b0);
        // Each circuit bit alone, then every code of the three coded fields.
        for (int b = 0; b < 16; b++) begin
            ci_put(6'h00, 5'h00, 16'h0001 << b, 1'b1);
            rd(16'h0104, 16'h0001 << b, 1'b0, 0);
        end
        for (int k = 0; k < 4; k++) begin
            w = (16'(k) << 14) | (16'(k) << 5) | (16'(k) << 2);
            ci_put(6'h01, 5'h05, w, k != 0);
            rd(16'h0121, w, 1'b0, 1);
        end
        ci_put(6'h3f, 5'h17, 16'h1f00, 1'b1);
        rd(16'h0703, 16'h1f00, 1'b0, 0);
        // A slot beyond the last one must not spill into the next substation.
        ci_put(6'h00, 5'h18, 16'hffff, 1'b0);
        rd(16'h011c, 16'h0000, 1'b0, 0);
        foreach (w_un[i]) rd(w_un[i], 16'h0000, 1'b1, 0);
        u_cli.write_reg(16'h0004, 16'hffff, refused);
        chk_bit(1'b1, refused);
        rd(16'h0004, 16'h1000, 1'b0, 3);
        u_cli.write_reg(16'h0104, 16'h0000, refused);
        chk_bit(1'b1, refused);
        rd(16'h0104, 16'h8000, 1'b0, 0);
        // A reset in mid-run must clear every stored word, so nothing reads as installed.
        @(posedge i_ref_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        rd(16'h0004, 16'h0000, 1'b0, 0);
        rd(16'h0104, 16'h0000, 1'b0, 0);
        final_report();
    end

    // A hung handshake ends the run as a failure.
    initial begin
        repeat (5000) @(posedge i_ref_clk);
        fails++;
        final_report();
    end
endmodule // tb

// [verilog/lswp_status_bank.sv]
`timescale 1ns/1ps
`include "lswp_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Substation word bits 15 to 13 always read as zero.
// - Substation bit 11 is one while the critical loop is open.
// - Substation bits 12, 10, 9 and 5 report test, charger, circuit, general faults.
// - Substation bit 8 is one in service mode, zero in normal mode.
// - Substation bit 7 is one after a deep battery discharge.
// - Substation bit 6 is one while the batteries are charging.
// - Substation bit 4 is one on battery, zero on mains.
// - Substation bit 3 marks a running test, bit 2 marks mains present.
// - Substation bit 1 marks a working link, bit 0 an installed substation.
// - Circuit bits 15 to 14 hold the external-trigger configuration code.
// - Circuit bit 13 flags faulty fittings; bits 12 to 8 count fittings.
// - Circuit bit 7 flags a failed current check; bits 6 to 5 test status.
// - Circuit bit 4 is one while the circuit card is faulty.
// - Circuit bits 3 to 2 hold the default operating mode code.
// - Circuit bit 1 marks a working card link, bit 0 a fitted card.
// - The first circuit word sits at register 260, the rest follow consecutively.
module lswp_status_bank (
    // Clock and reset.
    input  wire logic                        i_ref_clk,
    input  wire logic                        i_rst,
    // Substation update from the supervising logic.
    input  wire logic                        i_st_upd,
    input  wire logic [`LSWP_ST_IDX_W-1:0]   i_st_index,
    input  wire logic                        i_st_test_fault,
    input  wire logic                        i_st_loop_open,
    input  wire logic                        i_st_charger_fault,
    input  wire logic                        i_st_circuits_fault,
    input  wire logic                        i_st_service_active,
    input  wire logic                        i_st_deep_discharge_seen,
    input  wire logic                        i_st_charging_active,
    input  wire logic                        i_st_general_fault,
    input  wire logic                        i_st_on_battery,
    input  wire logic                        i_st_test_running,
    input  wire logic                        i_st_mains_present,
    input  wire logic                        i_st_link_ok,
    input  wire logic                        i_st_present,
    // Circuit update from the supervising logic.
    input  wire logic                        i_ci_upd,
    input  wire logic [`LSWP_ST_IDX_W-1:0]   i_ci_station,
    input  wire logic [`LSWP_CI_SLOT_W-1:0]  i_ci_slot,
    input  wire lswp_pkg::lswp_trig_e        i_ci_trigger_cfg,
    input  wire logic                        i_ci_fitting_fault,
    input  wire logic [4:0]                  i_ci_fitting_count,
    input  wire logic                        i_ci_current_check_fail,
    input  wire lswp_pkg::lswp_test_e        i_ci_test_status,
    input  wire logic                        i_ci_card_fault,
    input  wire lswp_pkg::lswp_mode_e        i_ci_default_mode,
    input  wire logic                        i_ci_link_ok,
    input  wire logic                        i_ci_present,
    // Input-register access from the network stack.
    input  wire logic                        i_rd_req,
    input  wire logic [15:0]                 i_rd_addr,
    input  wire logic                        i_wr_req,
    input  wire logic [15:0]                 i_wr_addr,
    input  wire logic [15:0]                 i_wr_data,
    // Read answer and write refusal.
    output logic                             o_rd_valid,
    output logic [15:0]                      o_rd_data,
    output logic                             o_rd_illegal,
    output logic                             o_wr_refused,
    // Change events.
    output logic                             o_st_changed,
    output logic                             o_ci_changed
);

    ////////////////////////////////////////////////////////////////////////////
    // Word packing.

    lswp_pkg::lswp_word_t     st_word;
    lswp_pkg::lswp_word_t     ci_word;

    lswp_word_pack u_pack (
        .i_st_test_fault          (i_st_test_fault),
        .i_st_loop_open           (i_st_loop_open),
        .i_st_charger_fault       (i_st_charger_fault),
        .i_st_circuits_fault      (i_st_circuits_fault),
        .i_st_service_active      (i_st_service_active),
        .i_st_deep_discharge_seen (i_st_deep_discharge_seen),
        .i_st_charging_active     (i_st_charging_active),
        .i_st_general_fault       (i_st_general_fault),
        .i_st_on_battery          (i_st_on_battery),
        .i_st_test_running        (i_st_test_running),
        .i_st_mains_present       (i_st_mains_present),
        .i_st_link_ok             (i_st_link_ok),
        .i_st_present             (i_st_present),
        .i_ci_trigger_cfg         (i_ci_trigger_cfg),
        .i_ci_fitting_fault       (i_ci_fitting_fault),
        .i_ci_fitting_count       (i_ci_fitting_count),
        .i_ci_current_check_fail  (i_ci_current_check_fail),
        .i_ci_test_status         (i_ci_test_status),
        .i_ci_card_fault          (i_ci_card_fault),
        .i_ci_default_mode        (i_ci_default_mode),
        .i_ci_link_ok             (i_ci_link_ok),
        .i_ci_present             (i_ci_present),
        .o_station_word           (st_word),
        .o_circuit_word           (ci_word)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Index arithmetic.

    logic [`LSWP_CI_IDX_W-1:0] ci_upd_idx;
    logic                      ci_slot_ok;
    logic [6:0]                st_quad;
    logic [`LSWP_ST_IDX_W-1:0] rd_st_idx;
    logic                      rd_st_hit;
    logic [15:0]               rd_ci_off;
    logic [`LSWP_CI_IDX_W-1:0] rd_ci_idx;
    logic                      rd_ci_hit;

    // Flat circuit index is station times 24 plus slot; slots past 23 do not exist,
    // so such an update is dropped rather than aliased onto the next station.
    always_comb begin
        ci_upd_idx = {i_ci_station, 4'h0} + {1'b0, i_ci_station, 3'h0}
                   + {6'h00, i_ci_slot};
        ci_slot_ok = ({27'h000_0000, i_ci_slot} < `LSWP_CIRCUITS_PER_ST);
    end

    // Substation words sit at every fourth register from 4 to 256.
    always_comb begin
        st_quad   = i_rd_addr[8:2];
        rd_st_idx = 6'(st_quad - 7'h01);
        rd_st_hit = (i_rd_addr >= `LSWP_ST_BASE_ADDR) && (i_rd_addr <= `LSWP_ST_LAST_ADDR)
                 && (i_rd_addr[1:0] == 2'h0);
    end

    // Circuit words are consecutive from 260 onward.
    always_comb begin
        rd_ci_off = i_rd_addr - `LSWP_CI_BASE_ADDR;
        rd_ci_idx = rd_ci_off[`LSWP_CI_IDX_W-1:0];
        rd_ci_hit = (i_rd_addr >= `LSWP_CI_BASE_ADDR) && (i_rd_addr <= `LSWP_CI_LAST_ADDR);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State update.

    lswp_pkg::lswp_state_s state_q;
    lswp_pkg::lswp_state_s state_d;

    // Reads sample the stored word before any update in the same cycle, so a
    // client always sees a whole word, never half of an old and half of a new one.
    always_comb begin
        state_d            = state_q;
        state_d.rd_valid   = 1'b0;
        state_d.rd_illegal = 1'b0;
        state_d.wr_refused = 1'b0;
        state_d.st_changed = 1'b0;
        state_d.ci_changed = 1'b0;
        if (i_st_upd) begin
            state_d.station[i_st_index] = st_word;
            state_d.st_changed = (state_q.station[i_st_index] != st_word);
        end
        if (i_ci_upd && ci_slot_ok) begin
            state_d.circuit[ci_upd_idx] = ci_word;
            state_d.ci_changed = (state_q.circuit[ci_upd_idx] != ci_word);
        end
        if (i_rd_req) begin
            state_d.rd_valid = 1'b1;
            if (rd_st_hit) begin
                state_d.rd_data = state_q.station[rd_st_idx];
            end else if (rd_ci_hit) begin
                state_d.rd_data = state_q.circuit[rd_ci_idx];
            end else begin
                state_d.rd_data    = `LSWP_WORD_RESET;
                state_d.rd_illegal = 1'b1;
            end
        end
        // Writes never touch the words; the client is told it was refused.
        if (i_wr_req) begin
            state_d.wr_refused = 1'b1;
        end
    end

    // Synchronous reset clears every word, so nothing reads as installed.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    // Write address and data are accepted only to be discarded.
    logic wr_unused;
    assign wr_unused    = ^{i_wr_addr, i_wr_data};
    assign o_rd_valid   = state_q.rd_valid;
    assign o_rd_data    = state_q.rd_data;
    assign o_rd_illegal = state_q.rd_illegal;
    assign o_wr_refused = state_q.wr_refused;
    assign o_st_changed = state_q.st_changed;
    assign o_ci_changed = state_q.ci_changed;

endmodule // lswp_status_bank

// [verilog/lswp_word_pack.sv]
`timescale 1ns/1ps
`include "lswp_defines.svh"

module lswp_word_pack (
    // Substation flags.
    input  wire logic                 i_st_test_fault,
    input  wire logic                 i_st_loop_open,
    input  wire logic                 i_st_charger_fault,
    input  wire logic                 i_st_circuits_fault,
    input  wire logic                 i_st_service_active,
    input  wire logic                 i_st_deep_discharge_seen,
    input  wire logic                 i_st_charging_active,
    input  wire logic                 i_st_general_fault,
    input  wire logic                 i_st_on_battery,
    input  wire logic                 i_st_test_running,
    input  wire logic                 i_st_mains_present,
    input  wire logic                 i_st_link_ok,
    input  wire logic                 i_st_present,
    // Circuit fields.
    input  wire lswp_pkg::lswp_trig_e i_ci_trigger_cfg,
    input  wire logic                 i_ci_fitting_fault,
    input  wire logic [4:0]           i_ci_fitting_count,
    input  wire logic                 i_ci_current_check_fail,
    input  wire lswp_pkg::lswp_test_e i_ci_test_status,
    input  wire logic                 i_ci_card_fault,
    input  wire lswp_pkg::lswp_mode_e i_ci_default_mode,
    input  wire logic                 i_ci_link_ok,
    input  wire logic                 i_ci_present,
    // Packed words.
    output lswp_pkg::lswp_word_t      o_station_word,
    output lswp_pkg::lswp_word_t      o_circuit_word
);

    // Substation word; the top three bits are not implemented and stay zero.
    always_comb begin
        o_station_word = `LSWP_WORD_RESET;
        o_station_word[`LSWP_ST_UNUSED_HI:`LSWP_ST_UNUSED_LO] = 3'h0;
        o_station_word[`LSWP_ST_TEST_FAULT] = i_st_test_fault;
        o_station_word[`LSWP_ST_LOOP_OPEN]  = i_st_loop_open;
        o_station_word[`LSWP_ST_CHARGER]    = i_st_charger_fault;
        o_station_word[`LSWP_ST_CIRCUITS]   = i_st_circuits_fault;
        o_station_word[`LSWP_ST_SERVICE]    = i_st_service_active;
        o_station_word[`LSWP_ST_DEEP_DIS]   = i_st_deep_discharge_seen;
        o_station_word[`LSWP_ST_CHARGING]   = i_st_charging_active;
        o_station_word[`LSWP_ST_ERROR]      = i_st_general_fault;
        o_station_word[`LSWP_ST_BATTERY]    = i_st_on_battery;
        o_station_word[`LSWP_ST_TESTING]    = i_st_test_running;
        o_station_word[`LSWP_ST_MAINS]      = i_st_mains_present;
        o_station_word[`LSWP_ST_LINK]       = i_st_link_ok;
        o_station_word[`LSWP_ST_PRESENT]    = i_st_present;
    end

    // Circuit word; the reserved test code is passed through unaltered.
    always_comb begin
        o_circuit_word = `LSWP_WORD_RESET;
        o_circuit_word[`LSWP_CI_TRIG_HI:`LSWP_CI_TRIG_LO] = i_ci_trigger_cfg;
        o_circuit_word[`LSWP_CI_FIT_FAULT]                = i_ci_fitting_fault;
        o_circuit_word[`LSWP_CI_FIT_HI:`LSWP_CI_FIT_LO]   = i_ci_fitting_count;
        o_circuit_word[`LSWP_CI_CUR_FAIL]   = i_ci_current_check_fail;
        o_circuit_word[`LSWP_CI_TEST_HI:`LSWP_CI_TEST_LO] = i_ci_test_status;
        o_circuit_word[`LSWP_CI_CARD_FAULT] = i_ci_card_fault;
        o_circuit_word[`LSWP_CI_MODE_HI:`LSWP_CI_MODE_LO] = i_ci_default_mode;
        o_circuit_word[`LSWP_CI_LINK]       = i_ci_link_ok;
        o_circuit_word[`LSWP_CI_PRESENT]    = i_ci_present;
    end

endmodule // lswp_word_pack
